// [src/fsas_flash_aux.sv]
// serial flash auxiliary command handler: transfer, compare, rewrite, status, power-down
// How it works
// - transfer 53H, 10 page index bits, A18..A9 in 264 mode
// - 256 mode: index in A17..A8
// - transfer starts on select rise, busy
// - compare 60H, same address layout
// - compare busy, then bit 6 updated
// - bit 6 zero match, one mismatch
// - rewrite 58H, same address layout
// - rewrite: load then program, bounded busy
// - status D7H accepted at any time except in deep power-down
// - status byte msb first after opcode
// - status repeats with fresh contents
// - bit 7 ready one, busy zero
// - busy during all array operations
// - bit 1 reflects sector protection
// - bit 0 one for 256 page
// - fixed density code in bits 5..2
// - reset settles into standby
// - B9H enters deep power-down, bounded
// - deep power-down ignores all but resume
// - ABH resumes to standby, bounded
`timescale 1ns/10ps
module fsas_flash_aux #(
  parameter int TRANSFER_TIME_NS = 200000,
  parameter int COMPARE_TIME_NS = 200000,
  parameter int REWRITE_TIME_NS = 35000000,
  parameter int ENTER_POWERDOWN_TIME_NS = 3000,
  parameter int RESUME_POWERDOWN_TIME_NS = 35000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic page_cfg_256,
  input wire logic protect_en,
  input wire logic ext_busy,
  input wire logic mem_mismatch,
  output fsas_pkg::fsas_mem_req_t mem_cmd,
  output logic ready,
  output logic deep_pd
);
  // longest times round down to whole cycles, never below one
  localparam int XFER_N = TRANSFER_TIME_NS / fsas_pkg::CLK_PERIOD_NS;
  localparam int COMP_N = COMPARE_TIME_NS / fsas_pkg::CLK_PERIOD_NS;
  localparam int REWR_N = REWRITE_TIME_NS / fsas_pkg::CLK_PERIOD_NS;
  localparam int EDPD_N = ENTER_POWERDOWN_TIME_NS / fsas_pkg::CLK_PERIOD_NS;
  localparam int RDPD_N = RESUME_POWERDOWN_TIME_NS / fsas_pkg::CLK_PERIOD_NS;
  localparam int PROG_N = (REWR_N > XFER_N + 1) ? REWR_N - XFER_N : 1;
  // timers load count minus one and leave on zero
  localparam logic [23:0] XFER_LD = 24'((XFER_N > 1) ? XFER_N - 1 : 0);
  localparam logic [23:0] COMP_LD = 24'((COMP_N > 1) ? COMP_N - 1 : 0);
  localparam logic [23:0] PROG_LD = 24'((PROG_N > 1) ? PROG_N - 1 : 0);
  localparam logic [23:0] EDPD_LD = 24'((EDPD_N > 1) ? EDPD_N - 1 : 0);
  localparam logic [23:0] RDPD_LD = 24'((RDPD_N > 1) ? RDPD_N - 1 : 0);
  localparam logic [23:0] TMR_ZERO = 24'h000000;
  localparam logic [23:0] TMR_ONE = 24'h000001;

  // ---------------- serial clock domain ----------------
  logic frame_rst_n;
  logic [5:0] bit_cnt;
  logic [22:0] in_sh;
  fsas_pkg::fsas_cmd_t frm_cmd;
  logic frame_tgl;
  logic [7:0] out_sh;
  logic [2:0] out_idx;
  logic so_oe_q;
  logic [fsas_pkg::STAT_SYNC_W-1:0] stat_sck;
  logic status_cmd;
  // built on ref_clk below, declared here because the status sync reads it
  fsas_pkg::fsas_status_t status_q;

  // frame logic is cleared by select high, so it needs no edge after the frame
  assign frame_rst_n = rst_n & ~cs_n;

  // bit counter saturates so long status reads keep a stable count
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= fsas_pkg::CNT_FIRST;
    end else if (bit_cnt != fsas_pkg::CNT_MAX) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // opcode and address shift in msb first on rising edges
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      in_sh <= '0;
      frm_cmd <= '0;
      frame_tgl <= 1'b0;
    end else begin
      in_sh <= {in_sh[21:0], si};
      if (bit_cnt == fsas_pkg::CNT_FIRST) begin
        // a new frame marks itself and forgets the previous command
        frame_tgl <= ~frame_tgl;
        frm_cmd.op <= fsas_pkg::OP_NONE;
        frm_cmd.addr_ok <= 1'b0;
      end
      if (bit_cnt == fsas_pkg::OP_LAST) begin
        frm_cmd.op <= {in_sh[6:0], si};
      end
      if (bit_cnt == fsas_pkg::ADDR_LAST) begin
        frm_cmd.addr <= {in_sh[22:0], si};
        frm_cmd.addr_ok <= 1'b1;
      end
    end
  end

  // status byte carried into the serial domain bit by bit
  fsas_sync2 #(
    .W(fsas_pkg::STAT_SYNC_W)
  ) u_stat_sync (
    .clk(sck),
    .rst_n(rst_n),
    .d({deep_pd, status_q}),
    .q(stat_sck)
  );

  // status read is honoured at any time except in deep power-down
  assign status_cmd = (frm_cmd.op == fsas_pkg::OP_STATUS) && (bit_cnt >= fsas_pkg::OP_BITS) &&
                      !stat_sck[fsas_pkg::STAT_SYNC_W-1];

  // output changes on falling edges, reloading a fresh byte every eight
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_sh <= '0;
      out_idx <= fsas_pkg::OUT_IDX_FIRST;
      so_oe_q <= 1'b0;
    end else if (status_cmd) begin
      so_oe_q <= 1'b1;
      if (out_idx == fsas_pkg::OUT_IDX_FIRST) begin
        out_sh <= stat_sck[7:0];
      end else begin
        out_sh <= {out_sh[6:0], 1'b0};
      end
      out_idx <= out_idx + 3'h1;
    end
  end

  assign so = out_sh[7];
  assign so_oe = so_oe_q;

  // ---------------- reference clock domain ----------------
  logic cs_hi;
  logic cs_hi_d;
  logic cs_rise;
  logic seen_tgl;
  logic cmd_go;
  logic mismatch_q;
  logic [fsas_pkg::PAGE_W-1:0] page_sel;
  logic [23:0] timer;
  fsas_pkg::fsas_state_t state;

  fsas_pin_in #(
    .INIT(1'b1)
  ) u_cs_in (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pin(cs_n),
    .level(cs_hi)
  );

  // select rise found after filtering; frame fields are quiet by then
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_hi_d <= 1'b1;
      seen_tgl <= 1'b0;
    end else begin
      cs_hi_d <= cs_hi;
      if (cs_rise) begin
        seen_tgl <= frame_tgl;
      end
    end
  end

  assign cs_rise = cs_hi & ~cs_hi_d;
  // a frame with no clocks leaves the toggle alone and starts nothing
  assign cmd_go = cs_rise && (frame_tgl != seen_tgl);

  // page index position depends on page size
  assign page_sel = page_cfg_256 ? frm_cmd.addr[fsas_pkg::PAGE_LSB_256 +: fsas_pkg::PAGE_W] :
                                   frm_cmd.addr[fsas_pkg::PAGE_LSB_264 +: fsas_pkg::PAGE_W];

  // operation sequencer; reset lands in standby
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsas_pkg::ST_STANDBY;
      timer <= TMR_ZERO;
      mem_cmd <= '0;
    end else begin
      mem_cmd.req <= 1'b0;
      unique case (state)
        fsas_pkg::ST_STANDBY: begin
          // new commands are dropped while other array work is busy
          if (cmd_go && !ext_busy) begin
            case (frm_cmd.op)
              fsas_pkg::OP_XFER: begin
                if (frm_cmd.addr_ok) begin
                  state <= fsas_pkg::ST_XFER;
                  timer <= XFER_LD;
                  mem_cmd <= '{req: 1'b1, op: fsas_pkg::MEM_LOAD, page: page_sel};
                end
              end
              fsas_pkg::OP_COMP: begin
                if (frm_cmd.addr_ok) begin
                  state <= fsas_pkg::ST_COMP;
                  timer <= COMP_LD;
                  mem_cmd <= '{req: 1'b1, op: fsas_pkg::MEM_COMP, page: page_sel};
                end
              end
              fsas_pkg::OP_REWR: begin
                if (frm_cmd.addr_ok) begin
                  state <= fsas_pkg::ST_REWR_XFER;
                  timer <= XFER_LD;
                  mem_cmd <= '{req: 1'b1, op: fsas_pkg::MEM_LOAD, page: page_sel};
                end
              end
              fsas_pkg::OP_DPD: begin
                state <= fsas_pkg::ST_ENTER_DPD;
                timer <= EDPD_LD;
              end
              default: begin
              end
            endcase
          end
        end
        fsas_pkg::ST_XFER, fsas_pkg::ST_COMP, fsas_pkg::ST_REWR_PROG: begin
          if (timer != TMR_ZERO) begin
            timer <= timer - TMR_ONE;
          end else begin
            state <= fsas_pkg::ST_STANDBY;
          end
        end
        fsas_pkg::ST_REWR_XFER: begin
          // second half programs the same page back with erase
          if (timer != TMR_ZERO) begin
            timer <= timer - TMR_ONE;
          end else begin
            state <= fsas_pkg::ST_REWR_PROG;
            timer <= PROG_LD;
            mem_cmd.req <= 1'b1;
            mem_cmd.op <= fsas_pkg::MEM_PROG;
          end
        end
        fsas_pkg::ST_ENTER_DPD: begin
          if (timer != TMR_ZERO) begin
            timer <= timer - TMR_ONE;
          end else begin
            state <= fsas_pkg::ST_DPD;
          end
        end
        fsas_pkg::ST_DPD: begin
          // only resume wakes the part
          if (cmd_go && frm_cmd.op == fsas_pkg::OP_RESUME) begin
            state <= fsas_pkg::ST_RESUME;
            timer <= RDPD_LD;
          end
        end
        fsas_pkg::ST_RESUME: begin
          // commands sent during the wake interval are dropped
          if (timer != TMR_ZERO) begin
            timer <= timer - TMR_ONE;
          end else begin
            state <= fsas_pkg::ST_STANDBY;
          end
        end
      endcase
    end
  end

  // compare outcome kept until the next compare ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_q <= 1'b0;
    end else if (state == fsas_pkg::ST_COMP && timer == TMR_ZERO) begin
      mismatch_q <= mem_mismatch;
    end
  end

  // status byte rebuilt every cycle so repeated reads see fresh data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      deep_pd <= 1'b0;
    end else begin
      status_q.ready <= (state == fsas_pkg::ST_STANDBY) && !ext_busy;
      status_q.mismatch <= mismatch_q;
      status_q.density <= fsas_pkg::DENSITY_CODE;
      status_q.protect <= protect_en;
      status_q.page256 <= page_cfg_256;
      deep_pd <= (state == fsas_pkg::ST_DPD);
    end
  end

  assign ready = status_q.ready;

  // ---------------- checks ----------------
  sequence s_xfer_go;
    cmd_go && !ext_busy && state == fsas_pkg::ST_STANDBY && frm_cmd.op == fsas_pkg::OP_XFER && frm_cmd.addr_ok;
  endsequence

  sequence s_rewr_half;
    state == fsas_pkg::ST_REWR_XFER && timer == TMR_ZERO;
  endsequence

  a_xfer_start_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_xfer_go |=> state == fsas_pkg::ST_XFER && mem_cmd.req && mem_cmd.op == fsas_pkg::MEM_LOAD ##1 !ready)
    else $error("transfer did not start busy");

  a_page_index_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_xfer_go |=> mem_cmd.page == $past(page_sel))
    else $error("wrong page index taken");

  a_compare_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == fsas_pkg::ST_COMP && timer == TMR_ZERO) |=> ##1 status_q.mismatch == $past(mem_mismatch, 2))
    else $error("compare result not reported");

  a_rewrite_steps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_rewr_half |=> state == fsas_pkg::ST_REWR_PROG && mem_cmd.req && mem_cmd.op == fsas_pkg::MEM_PROG)
    else $error("rewrite did not program back");

  a_ready_busy_op: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state != fsas_pkg::ST_STANDBY || ext_busy) |=> !ready)
    else $error("ready shown while busy");

  a_ready_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == fsas_pkg::ST_STANDBY && !ext_busy) |=> ready)
    else $error("ready missing while idle");

  a_dpd_enter_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == fsas_pkg::ST_ENTER_DPD && timer == TMR_ZERO) |=> state == fsas_pkg::ST_DPD ##1 deep_pd)
    else $error("deep power-down not entered");

  a_dpd_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == fsas_pkg::ST_DPD && !(cmd_go && frm_cmd.op == fsas_pkg::OP_RESUME)) |=> state == fsas_pkg::ST_DPD)
    else $error("deep power-down left without resume");

  a_resume_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == fsas_pkg::ST_RESUME && timer == TMR_ZERO) |=> state == fsas_pkg::ST_STANDBY ##1 !deep_pd)
    else $error("resume did not reach standby");
endmodule

// [src/fsas_pkg.sv]
// shared constants and types for the serial flash auxiliary command block
package fsas_pkg;
  // command opcodes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_XFER = 8'h53;
  localparam logic [7:0] OP_COMP = 8'h60;
  localparam logic [7:0] OP_REWR = 8'h58;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  // serial bit counting within a frame
  localparam logic [5:0] CNT_FIRST = 6'h00;
  localparam logic [5:0] OP_LAST = 6'h07;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] ADDR_LAST = 6'h1F;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [2:0] OUT_IDX_FIRST = 3'h0;
  // page index position inside the 24-bit address
  localparam int PAGE_W = 10;
  localparam int PAGE_LSB_264 = 9;
  localparam int PAGE_LSB_256 = 8;
  // clock and timer
  localparam int CLK_PERIOD_NS = 25;
  localparam int TMR_W = 24;
  localparam int STAT_SYNC_W = 9;
  // density code, value arbitrary
  localparam logic [3:0] DENSITY_CODE = 4'h3;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_XFER = 3'b001,
    ST_COMP = 3'b010,
    ST_REWR_XFER = 3'b011,
    ST_REWR_PROG = 3'b100,
    ST_ENTER_DPD = 3'b101,
    ST_DPD = 3'b110,
    ST_RESUME = 3'b111
  } fsas_state_t;

  typedef enum logic [1:0] {
    MEM_NONE = 2'b00,
    MEM_LOAD = 2'b01,
    MEM_COMP = 2'b10,
    MEM_PROG = 2'b11
  } fsas_mem_op_t;

  // command captured on the serial clock
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic addr_ok;
  } fsas_cmd_t;

  // request to the page array
  typedef struct packed {
    logic req;
    fsas_mem_op_t op;
    logic [PAGE_W-1:0] page;
  } fsas_mem_req_t;

  // status byte, msb first
  typedef struct packed {
    logic ready;
    logic mismatch;
    logic [3:0] density;
    logic protect;
    logic page256;
  } fsas_status_t;
endpackage

// [src/fsas_pin_in.sv]
// three-flop pin input filter, change taken once stages two and three agree
`timescale 1ns/10ps
module fsas_pin_in #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2, keeping metastability away from the compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// [src/fsas_sync2.sv]
// two-flop level synchroniser for a group of independent status bits
`timescale 1ns/10ps
module fsas_sync2 #(
  parameter int W = fsas_pkg::STAT_SYNC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // bits are independent levels, so per-bit skew is harmless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [verif/fsas_host_model.sv]
// host serial controller model: drives select, serial clock and data in, samples data out
`timescale 1ns/10ps
module fsas_host_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  localparam realtime HALF = 62.5;

  // idle: deselected, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // send nb bits of d msb first, then clock nr more bits in; z where so is not driven
  task automatic frame(input logic [31:0] d, input int nb, input int nr, output logic [15:0] rx);
    rx = 16'h0000;
    #13 cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i++) begin
      si = (i < nb) ? d[31-i] : ~si;
      #HALF sck = 1'b1;
      if (i >= nb) rx = {rx[14:0], (so_oe === 1'b1) ? so : 1'bz};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // released data line toggles so a stale level is never trusted
    si = ~si;
    #200;
  endtask
endmodule

// [verif/test_serial_flash_aux_commands.sv]
// self-checking bench for the auxiliary command handler
`timescale 1ns/10ps
module test_serial_flash_aux_commands;
  localparam int XFER_N = 60;
  localparam int COMP_N = 50;
  localparam int REWR_N = 100;
  localparam int EDPD_N = 10;
  localparam int RDPD_N = 20;
  localparam int LAT = 8; // select filter plus launch delay
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic page_cfg_256 = 1'b0;
  logic protect_en = 1'b1;
  logic ext_busy = 1'b0;
  logic mem_mismatch = 1'b0;
  wire logic sck, cs_n, si, so, so_oe, ready, deep_pd;
  fsas_pkg::fsas_mem_req_t mem_cmd;
  fsas_pkg::fsas_mem_req_t reqs[$];
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] rx;

  fsas_flash_aux #(.TRANSFER_TIME_NS(1500), .COMPARE_TIME_NS(1250), .REWRITE_TIME_NS(2500),
    .ENTER_POWERDOWN_TIME_NS(250), .RESUME_POWERDOWN_TIME_NS(500)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .page_cfg_256(page_cfg_256), .protect_en(protect_en), .ext_busy(ext_busy),
    .mem_mismatch(mem_mismatch), .mem_cmd(mem_cmd), .ready(ready), .deep_pd(deep_pd));
  fsas_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  always #12.5 ref_clk = ~ref_clk;

  // every array request pulse is queued for the scenario to judge
  always @(posedge ref_clk) begin
    if (mem_cmd.req === 1'b1) reqs.push_back(mem_cmd);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // bounded wait for ready (sel 0) or deep_pd (sel 1) to reach lvl
  task automatic wait_lvl(input int sel, input logic lvl, input int maxc);
    for (int n = 0; n < maxc && ((sel == 0) ? ready : deep_pd) !== lvl; n++) begin
      @(posedge ref_clk);
      #2;
    end
    chk({15'h0000, (sel == 0) ? ready : deep_pd}, {15'h0000, lvl}, "flag level in time");
  endtask

  task automatic chk_req(input fsas_pkg::fsas_mem_op_t op, input logic [9:0] pg);
    fsas_pkg::fsas_mem_req_t r;
    r = 13'h0000;
    for (int n = 0; n < XFER_N + LAT && reqs.size() == 0; n++) @(posedge ref_clk);
    if (reqs.size() != 0) r = reqs.pop_front();
    chk({4'h0, r.op, r.page}, {4'h0, op, pg}, "array request");
  endtask

  // don't-care address bits set to ones so a wrong slice shows up
  function automatic logic [31:0] cmd(input logic [7:0] op, input logic [9:0] pg);
    return page_cfg_256 ? {op, 6'h3F, pg, 8'hFF} : {op, 5'h1F, pg, 9'h1FF};
  endfunction

  function automatic logic [7:0] stat(input logic rdy, input logic mm);
    return {rdy, mm, fsas_pkg::DENSITY_CODE, protect_en, page_cfg_256};
  endfunction

  task automatic set_mode(input logic cfg, input logic mm);
    @(posedge ref_clk);
    #2;
    page_cfg_256 = cfg;
    mem_mismatch = mm;
  endtask

  task automatic t_reset();
    repeat (2) @(posedge ref_clk);
    #2;
    chk({14'h0000, ready, deep_pd}, 16'h0002, "standby after reset");
  endtask

  task automatic t_compare(input logic cfg, input logic mm, input logic [9:0] pg);
    set_mode(cfg, mm);
    host.frame(cmd(fsas_pkg::OP_COMP, pg), 32, 0, rx);
    chk_req(fsas_pkg::MEM_COMP, pg);
    wait_lvl(0, 1'b0, 4);
    wait_lvl(0, 1'b1, COMP_N + LAT);
    host.frame({fsas_pkg::OP_STATUS, 24'h000000}, 8, 16, rx);
    chk(rx, {stat(1'b1, mm), stat(1'b1, mm)}, "status after compare");
  endtask

  task automatic t_transfer(input logic [9:0] pg);
    set_mode(1'b0, 1'b0);
    host.frame(cmd(fsas_pkg::OP_XFER, pg), 32, 0, rx);
    chk_req(fsas_pkg::MEM_LOAD, pg);
    host.frame({fsas_pkg::OP_STATUS, 24'h000000}, 8, 8, rx);
    chk(rx, {8'h00, stat(1'b0, 1'b0)}, "status while busy");
    wait_lvl(0, 1'b1, XFER_N + LAT);
  endtask

  task automatic t_rewrite(input logic [9:0] pg);
    set_mode(1'b1, 1'b0);
    host.frame(cmd(fsas_pkg::OP_REWR, pg), 32, 0, rx);
    chk_req(fsas_pkg::MEM_LOAD, pg);
    chk_req(fsas_pkg::MEM_PROG, pg);
    wait_lvl(0, 1'b1, REWR_N + LAT);
  endtask

  task automatic t_ext_busy();
    @(posedge ref_clk);
    #2 ext_busy = 1'b1;
    wait_lvl(0, 1'b0, 3);
    host.frame(cmd(fsas_pkg::OP_XFER, 10'h155), 32, 0, rx);
    repeat (20) @(posedge ref_clk);
    chk(16'(reqs.size()), 16'h0000, "command taken while busy");
    #2 ext_busy = 1'b0;
    wait_lvl(0, 1'b1, 4);
  endtask

  task automatic t_power_down();
    host.frame({fsas_pkg::OP_DPD, 24'h000000}, 8, 0, rx);
    wait_lvl(1, 1'b1, EDPD_N + LAT);
    host.frame({fsas_pkg::OP_STATUS, 24'h000000}, 8, 16, rx);
    chk(rx, 16'hZZZZ, "output driven in power-down");
    host.frame(cmd(fsas_pkg::OP_XFER, 10'h0F0), 32, 0, rx);
    repeat (20) @(posedge ref_clk);
    chk(16'(reqs.size()), 16'h0000, "command taken in power-down");
    // select stays high through the resume interval
    host.frame({fsas_pkg::OP_RESUME, 24'h000000}, 8, 0, rx);
    wait_lvl(1, 1'b0, RDPD_N + LAT);
    wait_lvl(0, 1'b1, RDPD_N + LAT);
    host.frame({fsas_pkg::OP_STATUS, 24'h000000}, 8, 8, rx);
    chk(rx, {8'h00, stat(1'b1, 1'b0)}, "status after resume");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    t_reset();
    t_compare(1'b0, 1'b1, 10'h2A5);
    t_compare(1'b1, 1'b0, 10'h15A);
    t_transfer(10'h3FF);
    t_rewrite(10'h000);
    t_ext_busy();
    t_power_down();
    tally_and_finish();
  end

  // watchdog well beyond the expected run of some 50 us
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
